// file: core/halt_pkg.sv
// shared constants and types for the standby controller
package halt_pkg;
  // register byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_LEVEL = 4'h8;
  // control field positions
  localparam int CTRL_HALT_MODE_LSB = 0;
  localparam int CTRL_WARMUP_LEN = 2;
  localparam int CTRL_QUICK_WARMUP = 3;
  localparam int CTRL_RELEASE_CLOCK = 4;
  localparam int CTRL_FAST_OSC = 5;
  localparam int CTRL_SLOW_OSC = 6;
  localparam int CTRL_STOP_DRIVE = 7;
  localparam int CTRL_CLOCK_PIN_OE = 8;
  localparam int CTRL_PRESCALER_RUN = 9;
  localparam logic [9:0] CTRL_RESET = 10'h300;
  // halt mode encodings
  localparam logic [1:0] MODE_RUN = 2'h0;
  localparam logic [1:0] MODE_STOP = 2'h1;
  localparam logic [1:0] MODE_IDLE_OSC = 2'h2;
  localparam logic [1:0] MODE_IDLE_IO = 2'h3;
  localparam logic [2:0] LEVEL_NMI = 3'h7;
  localparam logic [2:0] MASK_RESET = 3'h7;
  // warm-up lengths in cycles of the post-stop clock
  localparam int WARMUP_SHORT_LOG2 = 14;
  localparam int WARMUP_LONG_LOG2 = 16;
  localparam int WARMUP_QUICK_LOG2 = 4;
  localparam logic [16:0] WARMUP_SHORT =
    17'(1) << WARMUP_SHORT_LOG2;
  localparam logic [16:0] WARMUP_LONG =
    17'(1) << WARMUP_LONG_LOG2;
  localparam logic [16:0] WARMUP_QUICK =
    17'(1) << WARMUP_QUICK_LOG2;

  typedef enum logic [2:0] {
    ST_ACTIVE, ST_HALT_RUN, ST_HALT_IO, ST_HALT_OSC, ST_HALT_STOP,
    ST_WARMUP, ST_RELEASE
  } halt_state_t;

  typedef struct packed {
    logic nmi;
    logic ext_irq_zero;
    logic watchdog_irq;
    logic conversion_done_irq;
    logic other_irq;
    logic [2:0] level;
  } irq_req_t;

  typedef struct packed {
    logic wake;
    logic service;
  } wake_out_t;
endpackage

// file: core/halt_standby_release_control.sv
// standby controller: halt modes, wake-up, warm-up and stop pin state
// How it works
// R1: halt instruction enters mode from halt_mode_select: 00/11/10/01
// R2: maskable request below mask level never wakes; nmi always wakes
// R3: ext_irq_zero below mask wakes without service; flag stays set
// R4: enabled interrupt that wakes is serviced right after wake-up
// R5: resume-only release continues after halt without service
// R6: stop mode released by interrupt waits for the warm-up
// R7: nonmaskable sources carry level 7, never masked
// R8: level ext_irq_zero must stay high until service starts
// R9: reset wakes; ram kept, every setting returns to reset value
// R10: run halt keeps system clock, stops only the core
// R11: run halt samples requests on falling clock output edge
// R12: idle-io clocks chosen peripherals; no watchdog/conversion wake
// R13: software disables watchdog before idle-io halt
// R14: idle-osc stops system clock; clock pin held high if enabled
// R15: idle-osc detects requests unclocked, restarts synchronously
// R16: idle-osc and stop end only by nmi, ext_irq_zero or reset
// R17: software clears prescaler_run before idle-osc halt
// R18: stop halts oscillator; clock out resumes after warm-up count
// R19: warm-up 2^14 cycles, or 2^16 with warmup_length_select set
// R20: quick_warmup_select shortens warm-up for stable clocks
// R21: after stop run from clock picked by release_clock_select
// R22: software uses same clock mode before and after stop
// R23: stop outputs go high-z unless stop_pin_drive_enable is one
// R24: pull-ups from port data, or function data when active
// R25: warm-up counter starts at wake, done releases the core
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module halt_standby_release_control
  import halt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // core side
  input wire logic halt_exec,
  input wire logic [2:0] interrupt_mask_level,
  input wire logic ext_irq_zero_flag_set,
  output wake_out_t wake,
  output logic core_stalled,
  output logic ext_irq_zero_flag,
  // interrupt controller side
  input wire irq_req_t irq,
  // clock generator side
  input wire logic clock_out_ref,
  output logic sys_clock_enable,
  output logic osc_enable,
  output logic peripheral_clock_enable,
  output logic release_clock_select,
  output logic release_fast_osc_enable,
  output logic release_slow_osc_enable,
  output logic prescaler_run,
  output logic clock_pin_forced_high,
  // pins
  input wire logic [7:0] port_data,
  input wire logic [7:0] port_out_enable,
  input wire logic [7:0] func_active,
  input wire logic [7:0] func_data,
  output logic [7:0] pin_out_enable,
  output logic [7:0] pull_up_enable
);

  logic [9:0] ctrl;
  halt_state_t state, next_state;
  logic [16:0] warm_cnt;
  logic clk_out_q;
  logic clk_fall;
  logic wake_seen;
  logic wake_service;
  logic enabled_wake, ext_zero_resume, async_wake;
  logic [1:0] mode;
  logic access_pending;

  assign mode = ctrl[CTRL_HALT_MODE_LSB +: 2];

  // priority test: a level at or above the mask passes; nmi bypasses it and always wakes
  function automatic logic level_ok(input logic [2:0] lvl,
                                    input logic [2:0] mask);
    level_ok = lvl >= mask;
  endfunction

  // R7: nmi fixed top
  // R2: mask gate
  assign enabled_wake = irq.nmi ||
    (level_ok(irq.level, interrupt_mask_level) &&
     (irq.ext_irq_zero || irq.watchdog_irq ||
      irq.conversion_done_irq || irq.other_irq));
  // R3: resume-only wake
  assign ext_zero_resume = irq.ext_irq_zero &&
    !level_ok(irq.level, interrupt_mask_level);
  // R16: only external pins
  // R15: raw requests, no clock gating on this path
  assign async_wake = irq.nmi || irq.ext_irq_zero;

  // R11: clock output falling edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      // matches the pin's idle high level, so no edge is seen out of reset
      clk_out_q <= 1'b1;
    end else begin
      clk_out_q <= clock_out_ref;
    end
  end
  assign clk_fall = clk_out_q && !clock_out_ref;

  // avalon slave: one wait state, then answer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      access_pending <= 1'b0;
    end else begin
      access_pending <= (read || write) && !access_pending;
    end
  end
  assign waitrequest = (read || write) && !access_pending;

  // R9: reset restores every setting
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET;
    end else if (write && access_pending && address == ADDR_CTRL) begin
      ctrl <= writedata[9:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      readdata <= 32'h0;
    end else if (read && !access_pending) begin
      case (address)
        ADDR_CTRL: readdata <= {22'h0, ctrl};
        ADDR_STATUS: readdata <= {24'h0, ext_irq_zero_flag,
                                  wake_service, warm_cnt == 17'h0,
                                  core_stalled, 1'b0, state};
        ADDR_IRQ_LEVEL: readdata <= {29'h0, interrupt_mask_level};
        default: readdata <= 32'h0;
      endcase
    end
  end

  // wake decision per mode
  always_comb begin
    next_state = state;
    case (state)
      ST_ACTIVE: begin
        // R1: mode select
        if (halt_exec) begin
          case (mode)
            MODE_RUN: next_state = ST_HALT_RUN;
            MODE_IDLE_IO: next_state = ST_HALT_IO;
            MODE_IDLE_OSC: next_state = ST_HALT_OSC;
            MODE_STOP: next_state = ST_HALT_STOP;
            default: next_state = ST_HALT_RUN;
          endcase
        end
      end
      ST_HALT_RUN: begin
        // R11: sample on fall
        if (clk_fall && (enabled_wake || ext_zero_resume)) begin
          next_state = ST_RELEASE;
        end
      end
      ST_HALT_IO: begin
        // R12: watchdog and conversion excluded
        if ((irq.nmi || ext_zero_resume ||
             (level_ok(irq.level, interrupt_mask_level) &&
              (irq.ext_irq_zero || irq.other_irq)))) begin
          next_state = ST_RELEASE;
        end
      end
      ST_HALT_OSC: begin
        if (async_wake) begin
          next_state = ST_RELEASE;
        end
      end
      ST_HALT_STOP: begin
        // R6: warm-up first
        if (async_wake) begin
          next_state = ST_WARMUP;
        end
      end
      ST_WARMUP: begin
        // R25: done releases
        if (warm_cnt == 17'h1) begin
          next_state = ST_RELEASE;
        end
      end
      ST_RELEASE: next_state = ST_ACTIVE;
      default: next_state = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= ST_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  // captured at the wake edge; later mask moves don't change it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wake_seen <= 1'b0;
      wake_service <= 1'b0;
    end else if (state != ST_ACTIVE && state != ST_WARMUP &&
                 state != ST_RELEASE && next_state != state) begin
      wake_seen <= 1'b1;
      // R4: service enabled
      // R5: resume only
      wake_service <= enabled_wake;
    end else if (state == ST_RELEASE) begin
      wake_seen <= 1'b0;
    end
  end

  // R19: length select
  // R20: quick warm-up
  // R25: counter starts at wake
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      warm_cnt <= 17'h0;
    end else if (state == ST_HALT_STOP && async_wake) begin
      if (ctrl[CTRL_QUICK_WARMUP]) begin
        warm_cnt <= WARMUP_QUICK;
      end else if (ctrl[CTRL_WARMUP_LEN]) begin
        warm_cnt <= WARMUP_LONG;
      end else begin
        warm_cnt <= WARMUP_SHORT;
      end
    end else if (warm_cnt != 17'h0) begin
      warm_cnt <= warm_cnt - 17'h1;
    end
  end

  // R3: flag held at one
  // set wins over clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ext_irq_zero_flag <= 1'b0;
    end else if (ext_irq_zero_flag_set || irq.ext_irq_zero) begin
      ext_irq_zero_flag <= 1'b1;
    end else if (state == ST_RELEASE && wake_service) begin
      ext_irq_zero_flag <= 1'b0;
    end
  end

  assign wake.wake = state == ST_RELEASE && wake_seen;
  assign wake.service = state == ST_RELEASE && wake_service;
  // R10: core only
  assign core_stalled = state != ST_ACTIVE && state != ST_RELEASE;
  // R14: system clock off
  // R18: held until warm-up done
  // R12: idle-io feeds peripherals only
  assign sys_clock_enable = state == ST_ACTIVE ||
    state == ST_HALT_RUN || state == ST_RELEASE;
  assign osc_enable = state != ST_HALT_STOP;
  assign peripheral_clock_enable = state != ST_HALT_OSC &&
    state != ST_HALT_STOP && state != ST_WARMUP;
  // R14: clock pin high
  assign clock_pin_forced_high = state == ST_HALT_OSC &&
    ctrl[CTRL_CLOCK_PIN_OE];
  // R21: release clock choice
  assign release_clock_select = ctrl[CTRL_RELEASE_CLOCK];
  assign release_fast_osc_enable = ctrl[CTRL_FAST_OSC];
  assign release_slow_osc_enable = ctrl[CTRL_SLOW_OSC];
  assign prescaler_run = ctrl[CTRL_PRESCALER_RUN];

  // R23: stop pin drive
  assign pin_out_enable = (state == ST_HALT_STOP &&
    !ctrl[CTRL_STOP_DRIVE]) ? 8'h00 : port_out_enable;
  // R24: pull-up source
  assign pull_up_enable = (func_active & func_data) |
    (~func_active & port_data);
endmodule

// file: dv/halt_assertions.sv
// port assertions for the standby controller
`timescale 1ns/1ps
module halt_chk
  import halt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic halt_exec,
  input wire logic ext_irq_zero_flag_set,
  input wire irq_req_t irq,
  input wire wake_out_t wake,
  input wire logic core_stalled,
  input wire logic ext_irq_zero_flag,
  input wire logic sys_clock_enable,
  input wire logic osc_enable,
  input wire logic [7:0] port_data,
  input wire logic [7:0] port_out_enable,
  input wire logic [7:0] func_active,
  input wire logic [7:0] func_data,
  input wire logic [7:0] pin_out_enable,
  input wire logic [7:0] pull_up_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_halt_stalls:
    assert property (halt_exec && !core_stalled && !wake.wake |=> core_stalled)
    else $error("halt not entered");
  chk_bus_answer:
    assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  chk_service_wake:
    assert property (wake.service |-> wake.wake) else $error("service alone");
  chk_wake_pulse:
    assert property (wake.wake |=> !wake.wake) else $error("wake too long");
  chk_nmi_wakes:
    assert property (core_stalled && irq.nmi && sys_clock_enable
      |-> ##[0:4] wake.wake) else $error("nmi ignored");
  chk_pins_active:
    assert property (!core_stalled |-> pin_out_enable == port_out_enable)
    else $error("pin enable wrong");
  chk_pullup_src:
    assert property (pull_up_enable ==
      (func_active & func_data | ~func_active & port_data))
    else $error("pull-up wrong");
  chk_osc_sys:
    assert property (!osc_enable |-> !sys_clock_enable)
    else $error("clock without osc");
  chk_flag_set:
    assert property (ext_irq_zero_flag_set |=> ext_irq_zero_flag)
    else $error("flag not set");
endmodule

// file: dv/core_model.sv
// clock output of the core side, parked high when clocks stop
`timescale 1ns/1ps
module core_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sys_clock_enable,
  input wire logic peripheral_clock_enable,
  output logic clock_out_ref
);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) clock_out_ref <= 1'b1;
    else if (sys_clock_enable || peripheral_clock_enable)
      clock_out_ref <= !clock_out_ref;
    else clock_out_ref <= 1'b1;
  end
endmodule

// file: dv/tb.sv
// self-checking bench for the standby controller
`timescale 1ns/1ps
module tb;
  import halt_pkg::*;
  logic clk_sys = 0, rstn = 0, read = 0, write = 0, halt_exec = 0;
  logic [3:0] address = 0;
  logic [31:0] writedata = 0, readdata, q;
  logic waitrequest, core_stalled, ext_irq_zero_flag, clock_out_ref;
  logic [2:0] interrupt_mask_level = 0;
  logic ext_irq_zero_flag_set = 0;
  wake_out_t wake;
  irq_req_t irq = '0, r;
  logic sys_clock_enable, osc_enable, peripheral_clock_enable;
  logic release_clock_select, release_fast_osc_enable;
  logic release_slow_osc_enable, prescaler_run, clock_pin_forced_high;
  logic [7:0] port_data = 0, port_out_enable = 0, func_active = 0;
  logic [7:0] func_data = 0, pin_out_enable, pull_up_enable;
  logic [9:0] c, m;
  int err_total = 0, check_count = 0, seed = 13620, i, n, e, w;
  // halt mode plus options; irq {nmi,ext0,wdt,conv,other,level}; mask
  logic [9:0] ctl_t[10] = '{10'h000, 10'h000, 10'h003, 10'h003,
    10'h102, 10'h102, 10'h009, 10'h089, 10'h001, 10'h003};
  logic [7:0] irq_t[10] = '{8'h87, 8'h0A, 8'h26, 8'h42, 8'h0E,
    8'h46, 8'h87, 8'h43, 8'h87, 8'h16};
  logic [2:0] mask_t[10] = '{3'h7, 3'h5, 3'h1, 3'h5, 3'h1, 3'h1, 3'h7,
    3'h5, 3'h7, 3'h1};
  halt_standby_release_control DUT (.*);
  core_model partner (.*);
  initial forever #4 clk_sys = !clk_sys;
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    // look at the settled level; the next rising edge is the taking one
    for (k = 0; k < 20; k++) begin
      @(negedge clk_sys);
      if (waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      err_total++;
      finish_test();
    end
    @(posedge clk_sys);
    q = readdata;
    read <= 0;
    write <= 0;
  endtask
  task automatic wait_wake(input int lim, input bit must);
    for (n = 0; n < lim; n++) begin
      @(negedge clk_sys);
      if (wake.wake === 1'b1) break;
    end
    if (must && n == lim) begin err_total++; finish_test(); end
  endtask
  // 0 none, 1 resume only, 2 serviced
  function automatic int exp_wake(input logic [1:0] md, input int mk);
    bit en = r.level >= mk;
    if (r.nmi) return 2;
    if (r.ext_irq_zero) return en ? 2 : 1;
    if (md == MODE_IDLE_OSC || md == MODE_STOP || !en) return 0;
    if (md == MODE_IDLE_IO && (r.watchdog_irq || r.conversion_done_irq))
      return 0;
    return 2;
  endfunction
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1;
    bus(0, ADDR_CTRL, 0); chk(q, 32'(CTRL_RESET)); // reset value
    bus(0, 4'hC, 0); chk(q, 0);
    for (i = 0; i < 10; i++) begin
      // options drawn at random, mode kept across stop
      c = ctl_t[i] | (10'($random(seed)) & 10'h270);
      {port_data, port_out_enable, func_active, func_data} <= $random(seed);
      interrupt_mask_level <= mask_t[i];
      ext_irq_zero_flag_set <= 1;
      bus(1, ADDR_CTRL, 32'(c));
      ext_irq_zero_flag_set <= 0;
      halt_exec <= 1;
      @(posedge clk_sys);
      halt_exec <= 0;
      @(negedge clk_sys);
      // ctrl lands on the bus edge; look only once it has settled
      chk({prescaler_run, release_slow_osc_enable, release_fast_osc_enable,
        release_clock_select}, {c[9], c[6], c[5], c[4]});
      m = {c[8], c[7], 6'h0, c[1:0]};
      chk({core_stalled, sys_clock_enable, osc_enable, clock_pin_forced_high,
        pin_out_enable}, {1'b1, m[1:0] == MODE_RUN, m[1:0] != MODE_STOP,
        m[1:0] == MODE_IDLE_OSC && m[9], (m[1:0] == MODE_STOP && !m[8])
        ? 8'h00 : port_out_enable});
      chk(32'(peripheral_clock_enable), 32'(m[1:0] == MODE_RUN ||
        m[1:0] == MODE_IDLE_IO));
      @(posedge clk_sys);
      r = irq_req_t'(irq_t[i]);
      irq <= r; // held until release, no watchdog at wake
      e = exp_wake(c[1:0], mask_t[i]);
      w = c[1:0] != MODE_STOP ? 0 : c[3] ? int'(WARMUP_QUICK)
        : c[2] ? int'(WARMUP_LONG) : int'(WARMUP_SHORT);
      wait_wake(w + 40, e != 0);
      if (e == 0) begin
        chk(32'(n), 32'(w + 40));
        @(posedge clk_sys);
        r = irq_req_t'(8'h87);
        irq <= r;
        e = 2;
        wait_wake(40, 1);
      end
      chk(32'(n >= w && n <= w + 6), 1);
      chk(32'(wake.service), 32'(e == 2));
      if (e == 1) chk(32'(ext_irq_zero_flag), 1);
      @(posedge clk_sys);
      irq <= '0;
      // serviced release clears the flag unless ext zero still asks
      @(negedge clk_sys);
      chk(32'(ext_irq_zero_flag), 32'(e == 1 || r.ext_irq_zero));
      @(posedge clk_sys);
      $display("halt case %0d done", i);
    end
    bus(1, ADDR_CTRL, 0);
    halt_exec <= 1;
    @(posedge clk_sys);
    halt_exec <= 0;
    repeat (3) @(posedge clk_sys);
    rstn <= 0;
    @(posedge clk_sys);
    rstn <= 1;
    @(negedge clk_sys);
    chk(32'(core_stalled), 0); // reset wakes
    bus(0, ADDR_CTRL, 0); chk(q, 32'(CTRL_RESET)); // settings reset
    $display("reset case done");
    finish_test();
  end
endmodule

bind halt_standby_release_control halt_chk checker_inst (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .read(read),
  .write(write),
  .waitrequest(waitrequest),
  .halt_exec(halt_exec),
  .ext_irq_zero_flag_set(ext_irq_zero_flag_set),
  .irq(irq),
  .wake(wake),
  .core_stalled(core_stalled),
  .ext_irq_zero_flag(ext_irq_zero_flag),
  .sys_clock_enable(sys_clock_enable),
  .osc_enable(osc_enable),
  .port_data(port_data),
  .port_out_enable(port_out_enable),
  .func_active(func_active),
  .func_data(func_data),
  .pin_out_enable(pin_out_enable),
  .pull_up_enable(pull_up_enable)
);
